// ===== verilog/cs_pkg.sv
// cs_pkg: constants, types and register map of the clock select and prescale block
// assumes a 250 MHz core clock and a watchdog tick that is already synchronous to it
package cs_pkg;

   // ************************************************************
   // clock and timing
   // ************************************************************
   localparam int CLK_MHZ = 250;
   localparam int WDT_KHZ = 128;
   localparam int ROUT_CK = 14;
   localparam int WAKE_CK = 6;
   localparam int SU_SHORT_US = 4100;
   localparam int SU_LONG_US = 65000;
   localparam int SU_SHORT_TICKS = (SU_SHORT_US * WDT_KHZ + 999) / 1000;
   localparam int SU_LONG_TICKS = (SU_LONG_US * WDT_KHZ + 999) / 1000;
   localparam logic [2:0] PCE_WINDOW = 3'h4;
   localparam logic [2:0] PLL_MULT = 3'h6;

   // ************************************************************
   // register indices, byte address is four times the index
   // ************************************************************
   localparam logic [11:0] IDX_PRESCALE = 12'h061;
   localparam logic [11:0] IDX_SEL_A = 12'h062;
   localparam logic [11:0] IDX_SEL_B = 12'h063;
   localparam logic [11:0] IDX_STATUS = 12'h064;
   localparam logic [11:0] IDX_TRIM = 12'h066;

   // ************************************************************
   // codes and reset values
   // ************************************************************
   localparam logic [3:0] FUSE_RC = 4'h2;
   localparam logic [3:0] RST_RC_CFG = 4'h2;
   localparam logic [3:0] RST_PS = 4'h0;
   localparam logic [3:0] DIV8_PS = 4'h3;
   localparam logic [3:0] PS_MAX = 4'h8;
   localparam logic [7:0] PCE_ARM = 8'h80;
   localparam logic [1:0] SUT_SHORT = 2'h1;
   localparam logic [1:0] SUT_LONG = 2'h2;

   // ************************************************************
   // types
   // ************************************************************
   typedef enum logic [2:0] {SU_CK, SU_MS, SU_RUN, SU_SLEEP, SU_WAKE} cs_su_t;

   typedef struct packed {
      logic [3:0] source;
      logic [1:0] startup;
      logic div8;
      logic clock_out;
      logic [7:0] cal;
   } cs_fuse_t;

   typedef struct packed {
      logic boot;
      logic [1:0] rc_sut;
      logic [1:0] ext_sut;
      logic rc_osc_enable;
      logic ext_osc_enable;
      logic cpu_clock_select;
      logic [3:0] rc_cfg;
      logic [3:0] ext_cfg;
      logic [7:0] trim;
      logic pce;
      logic [2:0] pce_cnt;
      logic [3:0] ps;
      logic ps_pend;
      logic [3:0] div_cur;
      logic [7:0] div_cnt;
      logic clk_out;
      cs_su_t ph;
      logic [13:0] su_cnt;
      logic [1:0] su_code;
      logic [31:0] rdata;
      logic err;
   } cs_state_t;

   localparam cs_state_t CS_ST_RESET = '{
      rc_cfg: RST_RC_CFG,
      ps: RST_PS,
      div_cur: RST_PS,
      ph: SU_CK,
      su_cnt: 14'(ROUT_CK),
      default: '0
   };

endpackage

// ===== verilog/cs_clock_ctrl.sv
// cs_clock_ctrl: clock source selection, start-up delays and glitch-free system prescaler
// assumes fuses are stable around reset and all inputs are synchronous to clk_i
// Functional notes
// - RC oscillator is default, chosen by RC fuse code
// - factory trim loaded into trim register at reset
// - reset time-out counts watchdog oscillator ticks only
// - RC start-up: 6 CK wake, 14 CK plus delay
// - external start-up uses same startup fuse codes
// - clock output fuse drives pin, even in reset
// - clock pin carries the divided clock, held high at divide by one
// - one divided enable feeds CPU, I/O, flash
// - division changes without glitch or runt pulse
// - no interim period shorter than old or new
// - new division active once the old period ends
// - prescaler is a counter on the undivided clock
// - arm change-enable, then write select within four
// - USB PLL multiplies 8 MHz reference by six
// - RC start-up field fuse-loaded, writes ignored
// - external start-up field fuse-loaded, software writable
// - RC enable bit starts and stops RC oscillator
// - external enable bit starts and stops external oscillator
// - CPU clock select, set at reset if external
// - RC source config resets to 0010
// - running flags reflect each oscillator state
// - select codes 0-8 divide by 1 to 256
// - change-enable self-clears after four cycles, no extend
`timescale 1ns/1ps

module cs_clock_ctrl
   import cs_pkg::*;
#(
   parameter logic [13:0] SU_LONG_TICKS_P = 14'(SU_LONG_TICKS)
) (
   // clock and reset
   input wire logic clk_i,
   input wire logic reset_n_i,
   // apb slave
   input wire logic [11:0] paddr_i,
   input wire logic psel_i,
   input wire logic penable_i,
   input wire logic pwrite_i,
   input wire logic [31:0] pwdata_i,
   output logic [31:0] prdata_o,
   output logic pready_o,
   output logic pslverr_o,
   // fuses and oscillator status
   input wire cs_fuse_t fuse_i,
   input wire logic rc_running_i,
   input wire logic ext_running_i,
   input wire logic wdt_tick_i,
   input wire logic sleep_i,
   // oscillator control
   output logic rc_osc_en_o,
   output logic ext_osc_en_o,
   output logic [7:0] rc_trim_o,
   output logic cpu_clk_sel_o,
   output logic [1:0] ext_startup_o,
   output logic [3:0] rc_source_cfg_o,
   output logic [3:0] ext_source_cfg_o,
   output logic [2:0] pll_mult_o,
   // system clock
   output logic cpu_run_o,
   output logic sys_clk_en_o,
   output logic clock_out_o,
   output logic clock_out_oe_o
);

   // ************************************************************
   // helpers
   // ************************************************************
   function automatic logic hit(input logic [11:0] a, input logic [11:0] idx);
      return a == {idx[9:0], 2'b00};
   endfunction

   // reserved codes above eight fall back to the slowest rate
   function automatic logic [7:0] last_cnt(input logic [3:0] c);
      logic [8:0] p;
      p = (c > PS_MAX) ? 9'h100 : (9'h001 << c);
      return 8'(p - 9'h001);
   endfunction

   cs_state_t st_reg;
   cs_state_t st_next;
   logic apb_wr;
   logic apb_setup;
   logic div_edge;
   logic run;
   logic [7:0] next_last;

   assign apb_wr = psel_i & penable_i & pwrite_i;
   assign apb_setup = psel_i & ~penable_i;
   assign div_edge = st_reg.div_cnt == last_cnt(st_reg.div_cur);
   assign run = st_reg.ph == SU_RUN;

   // ************************************************************
   // next state
   // ************************************************************
   always_comb begin
      st_next = st_reg;
      next_last = 8'h00;

      // catch fuses once, the cycle after reset release
      if (!st_reg.boot) begin
         st_next.boot = 1'b1;
         st_next.trim = fuse_i.cal;
         st_next.ps = fuse_i.div8 ? DIV8_PS : RST_PS;
         st_next.div_cur = st_next.ps;
         st_next.su_code = fuse_i.startup;
         if (fuse_i.source == FUSE_RC) begin
            st_next.rc_sut = fuse_i.startup;
            st_next.rc_osc_enable = 1'b1;
         end else begin
            st_next.ext_sut = fuse_i.startup;
            st_next.ext_cfg = fuse_i.source;
            st_next.ext_osc_enable = 1'b1;
            st_next.cpu_clock_select = 1'b1;
         end
      end

      // divider: the period only changes at its own last count, so no runt
      if (div_edge) begin
         st_next.div_cnt = 8'h00;
         if (st_reg.ps_pend) begin
            st_next.div_cur = st_reg.ps;
            st_next.ps_pend = 1'b0;
         end
      end else begin
         st_next.div_cnt = st_reg.div_cnt + 8'h01;
      end
      next_last = last_cnt(st_next.div_cur);
      st_next.clk_out = st_next.div_cnt <= (next_last >> 1);

      // change-enable time-out runs from the arming write, rewrites do not touch it
      if (st_reg.pce) begin
         st_next.pce_cnt = st_reg.pce_cnt - 3'h1;
         if (st_reg.pce_cnt == 3'h1) begin
            st_next.pce = 1'b0;
         end
      end

      // register writes
      if (apb_wr && hit(paddr_i, IDX_SEL_A)) begin
         st_next.ext_sut = pwdata_i[5:4];
         st_next.rc_osc_enable = pwdata_i[3];
         st_next.ext_osc_enable = pwdata_i[2];
         st_next.cpu_clock_select = pwdata_i[0];
      end
      if (apb_wr && hit(paddr_i, IDX_SEL_B)) begin
         st_next.rc_cfg = pwdata_i[7:4];
         st_next.ext_cfg = pwdata_i[3:0];
      end
      if (apb_wr && hit(paddr_i, IDX_TRIM)) begin
         st_next.trim = pwdata_i[7:0];
      end
      if (apb_wr && hit(paddr_i, IDX_PRESCALE)) begin
         if (pwdata_i[7:0] == PCE_ARM) begin
            if (!st_reg.pce) begin
               st_next.pce = 1'b1;
               st_next.pce_cnt = PCE_WINDOW;
            end
         end else if (!pwdata_i[7] && st_reg.pce) begin
            st_next.ps = pwdata_i[3:0];
            st_next.ps_pend = 1'b1;
            st_next.pce = 1'b0;
         end
      end

      // start-up and wake-up sequencing
      case (st_reg.ph)
         SU_CK: begin
            if (st_reg.su_cnt == 14'h0001) begin
               if (st_reg.su_code == SUT_SHORT) begin
                  st_next.ph = SU_MS;
                  st_next.su_cnt = 14'(SU_SHORT_TICKS);
               end else if (st_reg.su_code == SUT_LONG) begin
                  st_next.ph = SU_MS;
                  st_next.su_cnt = SU_LONG_TICKS_P;
               end else begin
                  st_next.ph = SU_RUN;
               end
            end else begin
               st_next.su_cnt = st_reg.su_cnt - 14'h0001;
            end
         end
         SU_MS: begin
            // the time-out rides the watchdog oscillator, not the chip clock
            if (wdt_tick_i) begin
               if (st_reg.su_cnt == 14'h0001) begin
                  st_next.ph = SU_RUN;
               end else begin
                  st_next.su_cnt = st_reg.su_cnt - 14'h0001;
               end
            end
         end
         SU_RUN: begin
            if (sleep_i) begin
               st_next.ph = SU_SLEEP;
            end
         end
         SU_SLEEP: begin
            if (!sleep_i) begin
               st_next.ph = SU_WAKE;
               st_next.su_cnt = 14'(WAKE_CK);
            end
         end
         SU_WAKE: begin
            if (st_reg.su_cnt == 14'h0001) begin
               st_next.ph = SU_RUN;
            end else begin
               st_next.su_cnt = st_reg.su_cnt - 14'h0001;
            end
         end
         default: begin
            st_next.ph = SU_CK;
         end
      endcase

      // read data is caught in the setup phase so the access phase needs no wait
      if (apb_setup) begin
         st_next.rdata = 32'h00000000;
         st_next.err = 1'b0;
         if (hit(paddr_i, IDX_SEL_A)) begin
            st_next.rdata[7:0] = {st_reg.rc_sut, st_reg.ext_sut, st_reg.rc_osc_enable,
                                  st_reg.ext_osc_enable, 1'b0, st_reg.cpu_clock_select};
         end else if (hit(paddr_i, IDX_SEL_B)) begin
            st_next.rdata[7:0] = {st_reg.rc_cfg, st_reg.ext_cfg};
         end else if (hit(paddr_i, IDX_STATUS)) begin
            st_next.rdata[1:0] = {rc_running_i, ext_running_i};
         end else if (hit(paddr_i, IDX_TRIM)) begin
            st_next.rdata[7:0] = st_reg.trim;
         end else if (hit(paddr_i, IDX_PRESCALE)) begin
            st_next.rdata[7:0] = {st_reg.pce, 3'b000, st_reg.ps};
         end else begin
            st_next.err = 1'b1;
         end
      end
   end

   always_ff @(posedge clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         st_reg <= CS_ST_RESET;
      end else begin
         st_reg <= st_next;
      end
   end

   // ************************************************************
   // outputs
   // ************************************************************
   assign prdata_o = st_reg.rdata;
   assign pready_o = 1'b1;
   assign pslverr_o = psel_i & penable_i & st_reg.err;
   assign rc_osc_en_o = st_reg.rc_osc_enable;
   assign ext_osc_en_o = st_reg.ext_osc_enable;
   assign rc_trim_o = st_reg.trim;
   assign cpu_clk_sel_o = st_reg.cpu_clock_select;
   assign ext_startup_o = st_reg.ext_sut;
   assign rc_source_cfg_o = st_reg.rc_cfg;
   assign ext_source_cfg_o = st_reg.ext_cfg;
   assign pll_mult_o = PLL_MULT;
   assign cpu_run_o = run;
   assign sys_clk_en_o = div_edge & run;
   // the enable follows the fuse live, so the pin is claimed in reset too; its level rests low there
   assign clock_out_o = st_reg.clk_out;
   assign clock_out_oe_o = fuse_i.clock_out;

   // ************************************************************
   // assertions
   // ************************************************************
   default clocking cb @(posedge clk_i);
   endclocking
   default disable iff (!reset_n_i);

   property p_pce_timeout;
      $rose(st_reg.pce) |-> ##[1:4] !st_reg.pce;
   endproperty
   a_pce_timeout: assert property (p_pce_timeout)
      else $error("change enable did not clear in four cycles");

   property p_ps_locked;
      (apb_wr && hit(paddr_i, IDX_PRESCALE) && !st_reg.pce) |=> $stable(st_reg.ps);
   endproperty
   a_ps_locked: assert property (p_ps_locked)
      else $error("prescale select changed without change enable");

   property p_bit1_zero;
      (apb_setup && hit(paddr_i, IDX_SEL_A)) |=> prdata_o[1] == 1'b0;
   endproperty
   a_bit1_zero: assert property (p_bit1_zero)
      else $error("reserved bit read as one");

   property p_rc_sut_ro;
      (st_reg.boot && apb_wr && hit(paddr_i, IDX_SEL_A)) |=> $stable(st_reg.rc_sut);
   endproperty
   a_rc_sut_ro: assert property (p_rc_sut_ro)
      else $error("rc start-up field took a write");

   property p_no_runt;
      (st_reg.boot && !div_edge) |=> $stable(st_reg.div_cur);
   endproperty
   a_no_runt: assert property (p_no_runt)
      else $error("division changed inside a period");

   property p_switch;
      (div_edge && st_reg.ps_pend) |=> st_reg.div_cur == $past(st_reg.ps) && !st_reg.ps_pend;
   endproperty
   a_switch: assert property (p_switch)
      else $error("pending division not taken at period end");

   property p_period4;
      (div_edge && !st_reg.ps_pend && st_reg.div_cur == 4'h2) |=> !div_edge [*3];
   endproperty
   a_period4: assert property (p_period4)
      else $error("divide by four period too short");

   property p_ext_boot;
      ($rose(st_reg.boot) && $past(fuse_i.source) != FUSE_RC)
         |-> st_reg.cpu_clock_select && st_reg.ext_osc_enable;
   endproperty
   a_ext_boot: assert property (p_ext_boot)
      else $error("external fuse did not select external clock");

   property p_status;
      (apb_setup && hit(paddr_i, IDX_STATUS))
         |=> prdata_o[1:0] == $past({rc_running_i, ext_running_i});
   endproperty
   a_status: assert property (p_status)
      else $error("running flags misreported");

   property p_run_gate;
      sys_clk_en_o |-> st_reg.ph == SU_RUN && div_edge;
   endproperty
   a_run_gate: assert property (p_run_gate)
      else $error("system enable outside run");

   c_ps_change: cover property ($rose(st_reg.ps_pend));
   c_long_start: cover property (st_reg.ph == SU_MS ##1 st_reg.ph == SU_RUN);
   c_wake: cover property (st_reg.ph == SU_WAKE ##[1:8] st_reg.ph == SU_RUN);
   c_bad_addr: cover property (pslverr_o);

endmodule

// ===== tb/tb_top.sv
// tb_top: self-checking bench for the clock select and prescale block
// assumes cs_pkg and cs_clock_ctrl are compiled first; assertions live in the design
`timescale 1ns/1ps

module tb_top
   import cs_pkg::*;
;
   // ************************************************************
   // signals
   // ************************************************************
   logic clk_i = 1'b0;
   logic reset_n_i = 1'b0;
   logic [11:0] paddr_i = '0;
   logic psel_i = 1'b0;
   logic penable_i = 1'b0;
   logic pwrite_i = 1'b0;
   logic [31:0] pwdata_i = '0;
   logic [31:0] prdata_o;
   logic pready_o, pslverr_o;
   cs_fuse_t fuse_i = '0;
   logic rc_running_i = 1'b0;
   logic ext_running_i = 1'b0;
   logic wdt_tick_i = 1'b0;
   logic sleep_i = 1'b0;
   logic rc_osc_en_o, ext_osc_en_o, cpu_clk_sel_o, cpu_run_o, sys_clk_en_o;
   logic clock_out_o, clock_out_oe_o;
   logic [7:0] rc_trim_o;
   logic [1:0] ext_startup_o;
   logic [3:0] rc_source_cfg_o, ext_source_cfg_o;
   logic [2:0] pll_mult_o;
   int fails = 0;
   int checks = 0;
   logic [31:0] seed = 32'h6CF35BCC;
   localparam logic [11:0] A_PS = {IDX_PRESCALE[9:0], 2'b00};
   localparam logic [11:0] A_SA = {IDX_SEL_A[9:0], 2'b00};
   localparam logic [11:0] A_SB = {IDX_SEL_B[9:0], 2'b00};
   localparam logic [11:0] A_ST = {IDX_STATUS[9:0], 2'b00};
   localparam logic [11:0] A_TR = {IDX_TRIM[9:0], 2'b00};

   // short long delay keeps the run brief; expectations use the same figure
   cs_clock_ctrl #(.SU_LONG_TICKS_P(14'h0014)) i_dut (
      .clk_i(clk_i), .reset_n_i(reset_n_i), .paddr_i(paddr_i), .psel_i(psel_i),
      .penable_i(penable_i), .pwrite_i(pwrite_i), .pwdata_i(pwdata_i),
      .prdata_o(prdata_o), .pready_o(pready_o), .pslverr_o(pslverr_o),
      .fuse_i(fuse_i), .rc_running_i(rc_running_i), .ext_running_i(ext_running_i),
      .wdt_tick_i(wdt_tick_i), .sleep_i(sleep_i), .rc_osc_en_o(rc_osc_en_o),
      .ext_osc_en_o(ext_osc_en_o), .rc_trim_o(rc_trim_o), .cpu_clk_sel_o(cpu_clk_sel_o),
      .ext_startup_o(ext_startup_o), .rc_source_cfg_o(rc_source_cfg_o),
      .ext_source_cfg_o(ext_source_cfg_o), .pll_mult_o(pll_mult_o),
      .cpu_run_o(cpu_run_o), .sys_clk_en_o(sys_clk_en_o), .clock_out_o(clock_out_o),
      .clock_out_oe_o(clock_out_oe_o)
   );

   always #2 clk_i = ~clk_i;
   // watchdog oscillator tick every second core cycle
   always @(posedge clk_i) wdt_tick_i <= ~wdt_tick_i;

   // ************************************************************
   // helpers
   // ************************************************************
   function automatic logic [31:0] rnd();
      seed = {seed[30:0], seed[31] ^ seed[21] ^ seed[1] ^ seed[0]};
      return seed;
   endfunction

   function automatic int div_of(input logic [3:0] c);
      return (c > PS_MAX) ? 256 : (1 << c);
   endfunction

   task automatic cmp32(input string nm, input logic [31:0] e, input logic [31:0] g);
      checks++;
      if (g !== e) begin
         fails++;
         $display("MISMATCH %s expected %h seen %h", nm, e, g);
      end
   endtask

   task automatic cmp1(input string nm, input logic e, input logic g);
      checks++;
      if (g !== e) begin
         fails++;
         $display("MISMATCH %s expected %b seen %b", nm, e, g);
      end
   endtask

   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
                      output logic [31:0] rd, output logic er);
      int n;
      n = 0;
      @(posedge clk_i);
      psel_i <= 1'b1;
      penable_i <= 1'b0;
      pwrite_i <= w;
      paddr_i <= a;
      pwdata_i <= d;
      @(posedge clk_i);
      penable_i <= 1'b1;
      do begin
         @(posedge clk_i);
         n++;
      end while (pready_o !== 1'b1 && n < 100);
      if (n >= 100) fails++;
      rd = prdata_o;
      er = pslverr_o;
      psel_i <= 1'b0;
      penable_i <= 1'b0;
   endtask

   task automatic rd_chk(input string nm, input logic [11:0] a, input logic [31:0] e);
      logic [31:0] r;
      logic er;
      apb(1'b0, a, '0, r, er);
      cmp32(nm, e, r);
      cmp1("pslverr", 1'b0, er);
   endtask

   task automatic wr(input logic [11:0] a, input logic [31:0] d);
      logic [31:0] r;
      logic er;
      apb(1'b1, a, d, r, er);
   endtask

   // gap between divided-clock pulses and high samples of the clock pin in it
   task automatic gap(output int n, output int hi);
      n = 0;
      hi = 0;
      do begin
         @(posedge clk_i);
         #1;
         n++;
         if (clock_out_o === 1'b1) hi++;
      end while (sys_clk_en_o !== 1'b1 && n < 600);
   endtask

   task automatic do_reset(input cs_fuse_t f, output int n);
      reset_n_i <= 1'b0;
      fuse_i <= f;
      repeat (3) @(posedge clk_i);
      #1;
      cmp1("oe in reset", f.clock_out, clock_out_oe_o);
      cmp32("rc cfg reset", 32'h2, 32'(rc_source_cfg_o));
      // release on a fixed tick phase so the time-out length is exact
      do begin
         @(posedge clk_i);
      end while (wdt_tick_i !== 1'b1);
      reset_n_i <= 1'b1;
      n = 0;
      do begin
         @(posedge clk_i);
         #1;
         n++;
      end while (cpu_run_o !== 1'b1 && n < 2000);
   endtask

   task automatic report_and_stop();
      $display("checks %0d fails %0d", checks, fails);
      if (fails == 0 && checks > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask

   initial begin
      #(4 * 60000);
      fails++;
      report_and_stop();
   end

   // ************************************************************
   // tests
   // ************************************************************
   initial begin
      cs_fuse_t f;
      logic [31:0] d, r;
      logic er;
      int n, h, g2, g3, cur, nw;
      logic [3:0] code;
      // rc source, no extra delay, divide by eight
      f = '{source: FUSE_RC, startup: 2'h0, div8: 1'b1, clock_out: 1'b1, cal: 8'(rnd())};
      do_reset(f, n);
      cmp32("rc start cycles", 32'(ROUT_CK), 32'(n));
      cmp32("trim", 32'(f.cal), 32'(rc_trim_o));
      cmp1("rc enable", 1'b1, rc_osc_en_o);
      cmp1("cpu sel", 1'b0, cpu_clk_sel_o);
      cmp32("pll", 32'h6, 32'(pll_mult_o));
      rd_chk("sel a", A_SA, 32'h08);
      rd_chk("sel b", A_SB, 32'h20);
      rd_chk("prescale", A_PS, 32'h03);
      gap(n, h);
      gap(n, h);
      cmp32("div8 gap", 32'd8, 32'(n));
      d = {24'h0, 8'(rnd())};
      rc_running_i <= 1'b1;
      ext_running_i <= 1'b1;
      wr(A_SA, d);
      rd_chk("sel a wr", A_SA, {26'h0, d[5:2], 1'b0, d[0]});
      cmp1("rce", d[3], rc_osc_en_o);
      cmp1("ext_osc_enable", d[2], ext_osc_en_o);
      cmp1("cpu_clock_select", d[0], cpu_clk_sel_o);
      cmp32("ext sut", 32'(d[5:4]), 32'(ext_startup_o));
      d = rnd();
      rc_running_i <= d[1];
      ext_running_i <= d[0];
      wr(A_ST, 32'h03);
      rd_chk("status", A_ST, {30'h0, d[1:0]});
      d = {24'h0, 8'(rnd())};
      wr(A_TR, d);
      rd_chk("trim rd", A_TR, d);
      cmp32("trim out", d, 32'(rc_trim_o));
      apb(1'b0, 12'h000, '0, r, er);
      cmp1("unmapped err", 1'b1, er);
      cmp32("unmapped data", 32'h0, r);
      $display("test registers done");
      // external source, both added delays
      for (int s = 1; s <= 2; s++) begin
         code = 4'(rnd());
         f = '{source: (code == FUSE_RC) ? 4'hF : code, startup: 2'(s), div8: 1'b0,
               clock_out: 1'b0, cal: 8'h00};
         do_reset(f, n);
         nw = 14 + 2 * ((s == 1) ? SU_SHORT_TICKS : 20);
         cmp32("ext start", 32'(nw), 32'(n));
         cmp1("ext cpu_clock_select", 1'b1, cpu_clk_sel_o);
         cmp1("ext en", 1'b1, ext_osc_en_o);
         cmp32("ext sut", 32'(s), 32'(ext_startup_o));
         cmp32("ext cfg", 32'(f.source), 32'(ext_source_cfg_o));
         cmp1("oe", 1'b0, clock_out_oe_o);
      end
      rd_chk("prescale", A_PS, 32'h00);
      $display("test external done");
      // every select code, then a reserved one
      cur = 1;
      for (int i = 0; i < 10; i++) begin
         code = (i < 9) ? 4'(i) : 4'(9 + rnd() % 7);
         nw = div_of(code);
         wr(A_PS, {24'h0, PCE_ARM});
         wr(A_PS, {28'h0, code});
         gap(n, h);
         gap(g2, h);
         gap(g3, h);
         cmp1("no short period", 1'b1, g2 >= ((cur < nw) ? cur : nw));
         cmp32("switch period", 32'(nw), 32'(g2));
         cmp32("new period", 32'(nw), 32'(g3));
         cmp32("pin high", 32'((nw == 1) ? 1 : nw / 2), 32'(h));
         rd_chk("ps rd", A_PS, {28'h0, code});
         cur = nw;
      end
      wr(A_PS, 32'h02);
      rd_chk("unarmed", A_PS, {28'h0, code});
      // re-arming does not extend the window, so the late select is dropped
      wr(A_PS, {24'h0, PCE_ARM});
      wr(A_PS, {24'h0, PCE_ARM});
      wr(A_PS, 32'h01);
      rd_chk("expired", A_PS, {28'h0, code});
      $display("test prescale done");
      sleep_i <= 1'b1;
      repeat (3) @(posedge clk_i);
      #1;
      cmp1("sleep run", 1'b0, cpu_run_o);
      @(posedge clk_i);
      sleep_i <= 1'b0;
      n = 0;
      do begin
         @(posedge clk_i);
         #1;
         n++;
      end while (cpu_run_o !== 1'b1 && n < 100);
      cmp1("wake delay", 1'b1, n >= 6 && n <= 7);
      $display("test sleep done");
      report_and_stop();
   end
endmodule
